// ### verilog/tbm_pkg.sv
// Constants and types shared by the two-byte channel value mapper
package tbm_pkg;
    // APB register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FIELD = 8'h04;
    localparam logic [7:0] OFF_REF = 8'h08;
    localparam logic [7:0] OFF_VHI = 8'h0c;
    localparam logic [7:0] OFF_VEQ = 8'h10;
    localparam logic [7:0] OFF_VLO = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    localparam logic [7:0] OFF_WORD = 8'h1c;
    localparam logic [7:0] OFF_OBJ = 8'h20;
    // Control field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_DIR = 1;
    localparam int CTRL_TYPE_LSB = 2;
    localparam int CTRL_AREA = 4;
    localparam int CTRL_RDFN = 5;
    localparam int CTRL_ACT_HI = 6;
    localparam int CTRL_ACT_EQ = 7;
    localparam int CTRL_ACT_LO = 8;
    localparam int FIELD_OFS_LSB = 8;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [4:0] WIDTH_RST = 5'h10;
    localparam logic [3:0] OFS_RST = 4'h0;
    // Modbus function codes
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [7:0] FC_READ_INPUT = 8'h04;
    localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
    // Register width
    localparam int REG_W = 16;
    // Channel types
    typedef enum logic [1:0] {
        TY_CONFIGURED = 2'b00,
        TY_UNSIGNED = 2'b01,
        TY_SIGNED = 2'b10
    } tbm_type_t;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_WAIT = 2'b10
    } tbm_state_t;
endpackage

// ### verilog/tbm_field.sv
// Bit field insert and extract within a 16-bit word register
`timescale 1ns/1ps
`default_nettype none
module tbm_field (
    input wire logic [15:0] word_in, // Register word to read or merge into
    input wire logic [15:0] val_in, // Value to insert
    input wire logic [4:0] width, // Field width in bits
    input wire logic [3:0] ofs, // Field offset from LSB
    output logic [15:0] extract, // Field value right aligned
    output logic [15:0] merged // Word with field replaced
);
    logic [15:0] mask;
    // Mask of width ones; widths above 16 saturate at a full word
    always_comb begin
        mask = (width >= 5'h10) ? 16'hffff : ((16'h0001 << width[3:0]) - 16'h0001);
        extract = (word_in >> ofs) & mask;
        merged = (word_in & ~(mask << ofs)) | ((val_in & mask) << ofs);
    end
endmodule
`default_nettype wire

// ### verilog/tbm_mapper.sv
// Two-byte channel value mapper with APB registers
//
// Function
// RQ1: KNX value above reference: nothing or write higher register value.
// RQ2: KNX value equal reference: nothing or write match register value.
// RQ3: KNX value below reference: nothing or write lower register value.
// RQ4: Polled field above reference: nothing or send higher object value.
// RQ5: Polled field equal reference: nothing or send match object value.
// RQ6: Polled field below reference: nothing or send lower object value.
// RQ7: KNX to Modbus updates use write single holding register, code 06.
// RQ8: Modbus to KNX reads use code 03 or 04 as configured.
// RQ9: Unsigned type area is high/low byte pair or configured bit field.
// RQ10: Configured field: width and LSB offset; defaults 16 and 0.
// RQ11: Width and offset ignored when high/low byte pair is chosen.
// RQ12: Software keeps width plus offset at most 16.
// RQ13: Software keeps values within the configured field width.
// RQ14: Signed type always maps onto the full high/low byte pair.
// RQ15: Configured type compares the field at given width and offset.
// RQ16: Every poll cycle re-reads the register and evaluates afterwards.
`timescale 1ns/1ps
`default_nettype none
module tbm_mapper #(
    parameter int ADDR_W = 8 // APB address width
) (
    input wire logic pclk, // APB clock, 20 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error for unmapped address
    input wire logic knx_valid, // Group value received, one cycle
    input wire logic [15:0] knx_value, // Received group value
    input wire logic poll_tick, // Polling cycle start, one cycle
    output logic mb_req, // Modbus request, held until mb_ack
    output logic [7:0] mb_func, // Modbus function code
    output logic [15:0] mb_wdata, // Word for single register write
    input wire logic mb_ack, // Modbus transaction done, one cycle
    input wire logic [15:0] mb_rdata, // Word read, valid with mb_ack
    output logic obj_send, // Send group object, one cycle
    output logic [15:0] obj_value // Value to send on group object
);
    // ========================================
    // State
    // ========================================
    typedef struct packed {
        logic [31:0] ctrl;
        logic [4:0] width;
        logic [3:0] ofs;
        logic [15:0] ref_val;
        logic [15:0] v_hi;
        logic [15:0] v_eq;
        logic [15:0] v_lo;
        logic [15:0] word;
        logic [15:0] last_obj;
        logic [2:0] cmp_flags;
        logic busy_write;
        tbm_pkg::tbm_state_t st;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic mb_req;
        logic [7:0] mb_func;
        logic [15:0] mb_wdata;
        logic obj_send;
        logic [15:0] obj_value;
    } tbm_state_s_t;

    tbm_state_s_t s_q, s_d;

    // Outcome of a three-way compare: 2 higher, 1 match, 0 lower
    function automatic logic [2:0] cmp3(input logic [15:0] a, input logic [15:0] b, input logic sgn);
        logic gt;
        gt = sgn ? ($signed(a) > $signed(b)) : (a > b);
        if (a == b) begin
            cmp3 = 3'b010;
        end else if (gt) begin
            cmp3 = 3'b100;
        end else begin
            cmp3 = 3'b001;
        end
    endfunction

    // Field geometry actually used; byte pair forces full word
    logic use_field;
    logic [4:0] eff_w;
    logic [3:0] eff_o;
    logic [15:0] fld_extract_word, fld_merge_word, fld_val, fld_ext, fld_mrg;
    tbm_pkg::tbm_type_t ch_type;
    logic ch_dir;

    always_comb begin
        ch_type = tbm_pkg::tbm_type_t'(s_q.ctrl[tbm_pkg::CTRL_TYPE_LSB +: 2]);
        ch_dir = s_q.ctrl[tbm_pkg::CTRL_DIR];
        // Signed type never uses a field, unsigned only when selected
        use_field = (ch_type == tbm_pkg::TY_CONFIGURED) ||
                    ((ch_type == tbm_pkg::TY_UNSIGNED) && s_q.ctrl[tbm_pkg::CTRL_AREA]); // RQ9 RQ11 RQ14
        eff_w = use_field ? s_q.width : tbm_pkg::WIDTH_RST; // RQ10 RQ15
        eff_o = use_field ? s_q.ofs : tbm_pkg::OFS_RST; // RQ10 RQ15
    end

    // Word being written merges into last known register image
    always_comb begin
        fld_extract_word = mb_rdata;
        fld_merge_word = s_q.word;
        fld_val = 16'h0000;
        if (ch_type == tbm_pkg::TY_CONFIGURED) begin
            case (cmp3(knx_value, s_q.ref_val, 1'b0))
                3'b100: fld_val = s_q.v_hi;
                3'b010: fld_val = s_q.v_eq;
                default: fld_val = s_q.v_lo;
            endcase
        end else begin
            fld_val = knx_value;
        end
    end

    tbm_field u_field (
        .word_in(fld_extract_word),
        .val_in(fld_val),
        .width(eff_w),
        .ofs(eff_o),
        .extract(fld_ext),
        .merged()
    );

    tbm_field u_merge (
        .word_in(fld_merge_word),
        .val_in(fld_val),
        .width(eff_w),
        .ofs(eff_o),
        .extract(),
        .merged(fld_mrg)
    );

    // ========================================
    // Next state
    // ========================================
    logic apb_setup, apb_wr, apb_rd, hit;
    logic [2:0] kc, pc;
    logic k_act;
    logic [15:0] k_word;

    always_comb begin
        s_d = s_q;
        s_d.obj_send = 1'b0;
        apb_setup = psel && !penable;
        apb_wr = psel && penable && pwrite && s_q.pready;
        apb_rd = apb_setup && !pwrite;
        hit = 1'b1;
        kc = cmp3(knx_value, s_q.ref_val, 1'b0);
        pc = cmp3(fld_ext, s_q.ref_val, 1'b0);
        k_act = 1'b0;
        k_word = fld_mrg;

        // APB: no wait state, ready in the first access cycle
        s_d.pready = apb_setup;
        case (paddr[7:0])
            tbm_pkg::OFF_CTRL, tbm_pkg::OFF_FIELD, tbm_pkg::OFF_REF, tbm_pkg::OFF_VHI,
            tbm_pkg::OFF_VEQ, tbm_pkg::OFF_VLO, tbm_pkg::OFF_STAT, tbm_pkg::OFF_WORD,
            tbm_pkg::OFF_OBJ: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        s_d.pslverr = apb_setup && !hit;
        if (apb_rd) begin
            case (paddr[7:0])
                tbm_pkg::OFF_CTRL: s_d.prdata = s_q.ctrl;
                tbm_pkg::OFF_FIELD: s_d.prdata = {20'h0, s_q.ofs, 3'h0, s_q.width};
                tbm_pkg::OFF_REF: s_d.prdata = {16'h0, s_q.ref_val};
                tbm_pkg::OFF_VHI: s_d.prdata = {16'h0, s_q.v_hi};
                tbm_pkg::OFF_VEQ: s_d.prdata = {16'h0, s_q.v_eq};
                tbm_pkg::OFF_VLO: s_d.prdata = {16'h0, s_q.v_lo};
                tbm_pkg::OFF_STAT: s_d.prdata = {27'h0, s_q.st, s_q.cmp_flags};
                tbm_pkg::OFF_WORD: s_d.prdata = {16'h0, s_q.word};
                tbm_pkg::OFF_OBJ: s_d.prdata = {16'h0, s_q.last_obj};
                default: s_d.prdata = 32'h0000_0000;
            endcase
        end else if (apb_setup) begin
            s_d.prdata = 32'h0000_0000;
        end
        // Writes land at the access edge while pready is high
        if (apb_wr) begin
            case (paddr[7:0])
                tbm_pkg::OFF_CTRL: s_d.ctrl = {23'h0, pwdata[8:0]};
                tbm_pkg::OFF_FIELD: begin
                    s_d.width = pwdata[4:0];
                    s_d.ofs = pwdata[tbm_pkg::FIELD_OFS_LSB +: 4];
                end
                tbm_pkg::OFF_REF: s_d.ref_val = pwdata[15:0];
                tbm_pkg::OFF_VHI: s_d.v_hi = pwdata[15:0];
                tbm_pkg::OFF_VEQ: s_d.v_eq = pwdata[15:0];
                tbm_pkg::OFF_VLO: s_d.v_lo = pwdata[15:0];
                default: begin
                end
            endcase
        end

        // Sequencer
        unique case (s_q.st)
            tbm_pkg::ST_IDLE: begin
                if (s_q.ctrl[tbm_pkg::CTRL_EN] && !ch_dir && knx_valid) begin
                    // Configured type writes only on a selected outcome
                    if (ch_type == tbm_pkg::TY_CONFIGURED) begin
                        s_d.cmp_flags = kc;
                        unique case (kc)
                            3'b100: k_act = s_q.ctrl[tbm_pkg::CTRL_ACT_HI]; // RQ1
                            3'b010: k_act = s_q.ctrl[tbm_pkg::CTRL_ACT_EQ]; // RQ2
                            default: k_act = s_q.ctrl[tbm_pkg::CTRL_ACT_LO]; // RQ3
                        endcase
                    end else begin
                        k_act = 1'b1; // RQ14
                    end
                    if (k_act) begin
                        s_d.word = k_word;
                        s_d.mb_wdata = k_word;
                        s_d.mb_func = tbm_pkg::FC_WRITE_SINGLE; // RQ7
                        s_d.mb_req = 1'b1;
                        s_d.busy_write = 1'b1;
                        s_d.st = tbm_pkg::ST_WAIT;
                    end
                end else if (s_q.ctrl[tbm_pkg::CTRL_EN] && ch_dir && poll_tick) begin
                    // Each poll issues a fresh read
                    s_d.mb_func = s_q.ctrl[tbm_pkg::CTRL_RDFN] ? tbm_pkg::FC_READ_INPUT
                                                               : tbm_pkg::FC_READ_HOLD; // RQ8 RQ16
                    s_d.mb_req = 1'b1;
                    s_d.busy_write = 1'b0;
                    s_d.st = tbm_pkg::ST_WAIT;
                end
            end
            tbm_pkg::ST_WAIT: begin
                if (mb_ack) begin
                    s_d.mb_req = 1'b0;
                    s_d.st = tbm_pkg::ST_IDLE;
                    if (!s_q.busy_write) begin
                        s_d.word = mb_rdata;
                        // Evaluate right after the read completes
                        if (ch_type == tbm_pkg::TY_CONFIGURED) begin
                            s_d.cmp_flags = pc; // RQ16
                            unique case (pc)
                                3'b100: begin
                                    s_d.obj_send = s_q.ctrl[tbm_pkg::CTRL_ACT_HI]; // RQ4
                                    s_d.obj_value = s_q.v_hi;
                                end
                                3'b010: begin
                                    s_d.obj_send = s_q.ctrl[tbm_pkg::CTRL_ACT_EQ]; // RQ5
                                    s_d.obj_value = s_q.v_eq;
                                end
                                default: begin
                                    s_d.obj_send = s_q.ctrl[tbm_pkg::CTRL_ACT_LO]; // RQ6
                                    s_d.obj_value = s_q.v_lo;
                                end
                            endcase
                        end else begin
                            s_d.obj_send = 1'b1;
                            s_d.obj_value = fld_ext; // RQ9 RQ14
                        end
                    end
                end
            end
            default: begin
                s_d.mb_req = 1'b0;
                s_d.st = tbm_pkg::ST_IDLE;
            end
        endcase
        // Object value only moves with a send, so a silent outcome keeps it
        if (s_d.obj_send) begin
            s_d.last_obj = s_d.obj_value;
        end else begin
            s_d.obj_value = s_q.obj_value;
        end
    end

    // ========================================
    // Registers
    // ========================================
    // Reset to constants only; field defaults to full word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.ctrl <= tbm_pkg::CTRL_RST;
            s_q.width <= tbm_pkg::WIDTH_RST; // RQ10
            s_q.ofs <= tbm_pkg::OFS_RST;
            s_q.st <= tbm_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign mb_req = s_q.mb_req;
    assign mb_func = s_q.mb_func;
    assign mb_wdata = s_q.mb_wdata;
    assign obj_send = s_q.obj_send;
    assign obj_value = s_q.obj_value;
endmodule
`default_nettype wire

// ### dv/tbm_mapper_chk.sv
// Port checker for the two-byte channel value mapper
`timescale 1ns/1ps
`default_nettype none
// ====
// Checker
module tbm_chk (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic mb_req, // Modbus request
    input wire logic mb_ack, // Modbus done
    input wire logic [7:0] mb_func, // Function code
    input wire logic [15:0] mb_wdata, // Write word
    input wire logic obj_send, // Object send pulse
    input wire logic [15:0] obj_value // Object value
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus answer timing
    AST_PREADY_ACCESS: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // Request framing towards the Modbus side
    AST_FUNC_CODE: assert property (mb_req |-> mb_func inside {8'h03, 8'h04, 8'h06})
        else $error("illegal function code");
    AST_REQ_HOLD: assert property (mb_req && !mb_ack |=> mb_req && $stable(mb_func) && $stable(mb_wdata))
        else $error("request changed before ack");
    AST_REQ_END: assert property (mb_req && mb_ack |=> !mb_req)
        else $error("request not ended after ack");
    // Object sends follow reads only
    AST_SEND_AFTER_READ: assert property (obj_send |-> $past(mb_ack) && $past(mb_func) != 8'h06)
        else $error("object sent without a read");
    AST_NO_SEND_WRITE: assert property (mb_req && mb_ack && mb_func == 8'h06 |=> !obj_send)
        else $error("object sent after a write");
    AST_SEND_PULSE: assert property (obj_send |=> !obj_send)
        else $error("obj_send longer than one cycle");
    AST_OBJ_HELD: assert property (!obj_send |-> obj_value == $past(obj_value))
        else $error("obj_value changed without send");
endmodule
bind tbm_mapper tbm_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .mb_req(mb_req), .mb_ack(mb_ack), .mb_func(mb_func),
    .mb_wdata(mb_wdata), .obj_send(obj_send), .obj_value(obj_value));
`default_nettype wire

// ### dv/tbm_mb_slave.sv
// Behavioural Modbus slave answering the mapper's requests
`timescale 1ns/1ps
`default_nettype none
// ====
// Slave model
module tbm_mb_slave (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic mb_req, // Request from mapper
    input wire logic [3:0] dly, // Answer delay in cycles
    input wire logic [15:0] rd_word, // Word returned on reads
    output logic mb_ack, // One-cycle done pulse
    output logic [15:0] mb_rdata // Read word, valid with ack
);
    logic [3:0] cnt_q;
    logic gap_q;
    // Gap cycle after ack, though the mapper has already dropped req by then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            gap_q <= 1'b0;
            mb_ack <= 1'b0;
        end else begin
            mb_ack <= 1'b0;
            gap_q <= mb_ack;
            if (mb_req && !mb_ack && !gap_q) begin
                if (cnt_q >= dly) begin
                    mb_ack <= 1'b1;
                    cnt_q <= 4'h0;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
    // Outside ack the line shows the inverse, never a stale match
    assign mb_rdata = mb_ack ? rd_word : ~rd_word;
endmodule
`default_nettype wire

// ### dv/tbm_mapper_tb.sv
// Self-checking bench of the two-byte channel value mapper
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench
module tbm_mapper_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic pready, pslverr, e, knx_valid = 1'b0, poll_tick = 1'b0, mb_req, mb_ack, obj_send;
    logic [15:0] knx_value = 16'h0, mb_wdata, mb_rdata, obj_value, rd_word = 16'h0, l_wr, l_obj;
    logic [15:0] n_xfer = 16'h0, n_obj = 16'h0, n;
    logic [7:0] mb_func, l_func;
    logic [3:0] dly = 4'h1;
    logic [15:0] vt [3] = '{16'ha5a5, 16'h0001, 16'h5a5a};
    logic [15:0] vr [3] = '{16'ha5a5, 16'h0001, 16'h0003};
    int bad_count = 0, n_tests = 0, cyc = 0;
    tbm_mapper dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .knx_valid(knx_valid), .knx_value(knx_value), .poll_tick(poll_tick), .mb_req(mb_req),
        .mb_func(mb_func), .mb_wdata(mb_wdata), .mb_ack(mb_ack), .mb_rdata(mb_rdata),
        .obj_send(obj_send), .obj_value(obj_value));
    tbm_mb_slave sl_u (.pclk(pclk), .presetn(presetn), .mb_req(mb_req), .dly(dly), .rd_word(rd_word),
        .mb_ack(mb_ack), .mb_rdata(mb_rdata));
    // 20 MHz clock
    initial begin
        forever #25 pclk = ~pclk;
    end
    task automatic final_report();
        if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        n_tests++;
        if (g !== x) begin
            bad_count++;
            $display("mismatch %s exp %h got %h", nm, x, g);
        end
    endtask
    // APB transfer held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // No assumed latency; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(input logic dir, input logic [1:0] ty, input logic ar, input logic fn,
        input logic [2:0] act);
        return {23'h0, act, fn, ar, ty, dir, 1'b1};
    endfunction
    // One event pulse, then time for the slowest slave answer
    task automatic ev(input logic poll, input logic [15:0] v);
        @(posedge pclk);
        poll_tick <= poll;
        knx_valid <= !poll;
        knx_value <= v;
        @(posedge pclk);
        poll_tick <= 1'b0;
        knx_valid <= 1'b0;
        repeat (20) @(posedge pclk);
    endtask
    // Transfer monitor and hang guard
    always @(posedge pclk) begin
        if (mb_req === 1'b1 && mb_ack === 1'b1) begin
            l_func <= mb_func;
            l_wr <= mb_wdata;
            n_xfer <= n_xfer + 16'h1;
        end
        if (obj_send === 1'b1) begin
            l_obj <= obj_value;
            n_obj <= n_obj + 16'h1;
        end
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, tbm_pkg::OFF_FIELD, 0);
        chk("field", 16'h0010, d[15:0]);
        chk("noerr", 16'h0, {15'h0, e});
        apb(0, 8'h30, 0);
        chk("slverr", 16'h1, {15'h0, e});
        apb(1, tbm_pkg::OFF_REF, 100);
        apb(1, tbm_pkg::OFF_VHI, 32'h0000_a5a5);
        apb(1, tbm_pkg::OFF_VEQ, 32'h0000_0001);
        apb(1, tbm_pkg::OFF_VLO, 32'h0000_5a5a);
        // Above, equal and below the reference
        apb(1, tbm_pkg::OFF_CTRL, ctl(0, tbm_pkg::TY_CONFIGURED, 0, 0, 3'h7));
        for (int i = 0; i < 3; i++) begin
            ev(0, 16'd101 - 16'(i));
            chk("wword", vt[i], l_wr);
            chk("wfunc", 16'h0006, {8'h0, l_func});
        end
        apb(1, tbm_pkg::OFF_CTRL, ctl(0, tbm_pkg::TY_CONFIGURED, 0, 0, 3'h5));
        n = n_xfer;
        ev(0, 16'd100);
        chk("noact", n, n_xfer);
        // Field at width 4, offset 4 merged into the last word
        apb(1, tbm_pkg::OFF_VLO, 32'h0000_0003);
        apb(1, tbm_pkg::OFF_FIELD, 32'h0000_0404);
        apb(1, tbm_pkg::OFF_CTRL, ctl(0, tbm_pkg::TY_CONFIGURED, 0, 0, 3'h7));
        ev(0, 16'd99);
        chk("fword", 16'h5a3a, l_wr);
        apb(1, tbm_pkg::OFF_CTRL, ctl(0, tbm_pkg::TY_UNSIGNED, 0, 0, 3'h0));
        ev(0, 16'h1234);
        chk("uword", 16'h1234, l_wr);
        apb(1, tbm_pkg::OFF_CTRL, ctl(0, tbm_pkg::TY_UNSIGNED, 1, 0, 3'h0));
        ev(0, 16'h0009);
        chk("ufield", 16'h1294, l_wr);
        apb(1, tbm_pkg::OFF_CTRL, ctl(0, tbm_pkg::TY_SIGNED, 1, 0, 3'h0));
        ev(0, 16'h8001);
        chk("sword", 16'h8001, l_wr);
        // Polled reads, both read codes, slow slave on the last
        apb(1, tbm_pkg::OFF_FIELD, 32'h0000_0010);
        for (int i = 0; i < 3; i++) begin
            apb(1, tbm_pkg::OFF_CTRL, ctl(1, tbm_pkg::TY_CONFIGURED, 0, i == 1, 3'h7));
            rd_word <= 16'd101 - 16'(i);
            dly <= (i == 2) ? 4'h6 : 4'h1;
            ev(1, 16'h0);
            chk("obj", vr[i], l_obj);
            chk("rfunc", (i == 1) ? 16'h0004 : 16'h0003, {8'h0, l_func});
        end
        apb(1, tbm_pkg::OFF_CTRL, ctl(1, tbm_pkg::TY_CONFIGURED, 0, 0, 3'h0));
        n = n_xfer;
        ev(1, 16'h0);
        chk("reread", n + 16'h1, n_xfer);
        chk("nosend", 16'h3, n_obj);
        apb(1, tbm_pkg::OFF_REF, 5);
        apb(1, tbm_pkg::OFF_FIELD, 32'h0000_0404);
        apb(1, tbm_pkg::OFF_CTRL, ctl(1, tbm_pkg::TY_CONFIGURED, 0, 0, 3'h7));
        rd_word <= 16'hff5f;
        ev(1, 16'h0);
        chk("fobj", 16'h0001, l_obj);
        apb(1, tbm_pkg::OFF_CTRL, ctl(1, tbm_pkg::TY_UNSIGNED, 1, 0, 3'h0));
        ev(1, 16'h0);
        chk("uobj", 16'h0005, l_obj);
        apb(1, tbm_pkg::OFF_CTRL, ctl(1, tbm_pkg::TY_SIGNED, 1, 1, 3'h0));
        ev(1, 16'h0);
        chk("sobj", 16'hff5f, l_obj);
        // Status images after the last polls
        apb(0, tbm_pkg::OFF_WORD, 0);
        chk("word", 16'hff5f, d[15:0]);
        apb(0, tbm_pkg::OFF_OBJ, 0);
        chk("lastobj", 16'hff5f, d[15:0]);
        apb(0, tbm_pkg::OFF_STAT, 0);
        chk("stat", 16'h0002, d[15:0]);
        final_report();
    end
endmodule
`default_nettype wire
